// >>> core/usc_cfg.svh
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

`define USC_CLK_MHZ         100
`define USC_REF_MHZ         48
`define USC_FLUSH_STEP_US   1000
`define USC_RING_PULSE_US   20000
`define USC_STRAP_CYCLES    4

`define USC_OFF_CTRL        8'h00
`define USC_OFF_BAUD        8'h04
`define USC_OFF_TMO         8'h08
`define USC_OFF_DATA        8'h0c
`define USC_OFF_STAT        8'h10
`define USC_OFF_DESC        8'h14

`define USC_CTRL_BITBANG    0
`define USC_CTRL_PULLDOWN   1
`define USC_CTRL_USB2       2
`define USC_CTRL_WAKE       3
`define USC_CTRL_VALID      4
`define USC_CTRL_DIR_LSB    8

`define USC_BAUD_FRAC_LSB   14
`define USC_RST_CTRL        32'h0000_0000
`define USC_RST_BAUD_N      14'h001a
`define USC_RST_TMO         8'h10

`define USC_BCD_USB11       16'h0110
`define USC_BCD_USB20       16'h0200
`define USC_DIV8_VAL0       17'h00008
`define USC_DIV8_VAL1       17'h0000c

`endif

// >>> core/usc_pkg.sv
package usc_pkg;
  typedef enum logic [0:0] {
    USC_STRAP_WAIT,
    USC_STRAP_RUN
  } usc_strap_e;
  typedef logic [7:0] usc_byte_t;
endpackage

// >>> core/usc_stream_if.sv
`timescale 1ns/1ps
interface usc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> core/usc_skid.sv
`timescale 1ns/1ps
module usc_skid #(
  parameter int W = 8
) (
  input wire logic    core_clk,
  input wire logic    resetn,
  usc_stream_if.snk   up,
  usc_stream_if.src   dn
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  wire          push = up.valid & up.ready;
  wire          pop  = dn.valid & dn.ready;

  // full and empty come straight from the count, so stalls are exact
  assign up.ready = (cnt != 2'h2);
  assign dn.valid = (cnt != 2'h0);
  assign dn.data  = mem[rp];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wp] <= up.data;
  end
endmodule // usc_skid

// >>> core/usc_top.sv
`timescale 1ns/1ps
`include "usc_cfg.svh"
// Summary of operation
// - memory pins float in reset; memory clock driven once out of reset
// - pulled-down memory clock at reset selects the alternate product id
// - pulled-down memory select selects 48MHz, open selects 6MHz
// - suspend indicator is low while the link is suspended
// - power enable low after configuration, high again on suspend
// - power source strap level gives bus or self powered mode
// - option pulls uart lines weakly low while power enable is high
// - residual receive data flushed after programmable 1 to 255 ms
// - prescaler divides by n plus eighths, fraction up to 0.875
// - value 1 gives 2 Mbaud, 0 gives 3 Mbaud, no fraction
// - host switches eight uart lines between uart and parallel io
// - parallel io bytes go out one by one at prescaler rate
// - rs485 driver enable stays asserted while sending break
// - only first 64 memory words used; pins free during reset
// - option reports a usb 2.0 descriptor instead of 1.1
// - absent or invalid memory: no serial number, default values
// - x16 oversampling tick derived from 48MHz reference, 14+3 bits
// - 20ms low ring pulse in suspend with wake enabled resumes host
module usc_top #(
  parameter int          MS_CYCLES   = `USC_FLUSH_STEP_US * `USC_CLK_MHZ,
  parameter int          RING_CYCLES = `USC_RING_PULSE_US * `USC_CLK_MHZ,
  parameter logic [15:0] PID_BASE    = 16'h1234, // arbitrary value
  parameter logic [15:0] PID_ALT     = 16'h1235, // arbitrary value
  parameter int          CFG_WORDS   = 64
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cfg_mem_clock_o,
  output logic             cfg_mem_clock_oe,
  input  wire logic        cfg_mem_clock_i,
  output logic             cfg_mem_select_o,
  output logic             cfg_mem_select_oe,
  input  wire logic        cfg_mem_select_i,
  output logic             cfg_mem_data_o,
  output logic             cfg_mem_data_oe,
  input  wire logic        cfg_mem_data_i,
  input  wire logic        usb_suspend,
  input  wire logic        usb_configured,
  output logic             sleep_n,
  output logic             power_enable_n,
  input  wire logic        power_source_strap,
  output logic             self_powered,
  output logic             op_clk_48,
  output logic             uart_pulldown,
  input  wire logic        rx_data_pending,
  input  wire logic        rx_activity,
  output logic             rx_flush_req,
  output logic             baud_x16_tick,
  input  wire logic        tx_busy,
  input  wire logic        tx_break,
  output logic             rs485_driver_enable,
  input  wire logic [7:0]  uart_line_o,
  input  wire logic [7:0]  uart_line_oe,
  output logic      [7:0]  line_o,
  output logic      [7:0]  line_oe,
  input  wire logic [7:0]  line_i,
  input  wire logic        ring_indicator_n,
  output logic             remote_wakeup,
  output logic      [15:0] product_id,
  output logic      [15:0] bcd_usb,
  output logic             serial_present,
  output logic      [6:0]  cfg_mem_words
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  usc_stream_if #(.W(8)) host_s ();
  usc_stream_if #(.W(8)) port_s ();

  usc_skid #(.W(8)) u_buf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .up       (host_s),
    .dn       (port_s)
  );

  logic [31:0]        ctrl;
  logic [13:0]        baud_n;
  logic [2:0]         baud_frac;
  logic [7:0]         tmo;
  usc_pkg::usc_strap_e strap_st;
  logic [2:0]         strap_cnt;
  logic               alt_pid;
  logic [1:0]         sk_sync;
  logic [1:0]         cs_sync;
  logic [1:0]         ps_sync;
  logic [1:0]         ri_sync;
  logic [7:0]         li_meta;
  logic [7:0]         li_sync;
  logic [6:0]         acc48;
  logic [17:0]        bacc;
  logic [31:0]        ms_cnt;
  logic [7:0]         ms_elapsed;
  logic [31:0]        ri_cnt;
  logic               ri_done;
  usc_pkg::usc_byte_t bb_out;

  // apb decode
  wire acc_ph   = psel & penable;
  wire sel_ctrl = (paddr == `USC_OFF_CTRL);
  wire sel_baud = (paddr == `USC_OFF_BAUD);
  wire sel_tmo  = (paddr == `USC_OFF_TMO);
  wire sel_data = (paddr == `USC_OFF_DATA);
  wire sel_stat = (paddr == `USC_OFF_STAT);
  wire sel_desc = (paddr == `USC_OFF_DESC);
  wire mapped   = sel_ctrl | sel_baud | sel_tmo | sel_data | sel_stat
                | sel_desc;
  wire data_wr  = acc_ph & pwrite & sel_data;
  // a data write waits while the buffer is full instead of dropping
  assign pready  = ~(data_wr & ~host_s.ready);
  assign pslverr = acc_ph & ~mapped;
  wire wr_en    = acc_ph & pwrite & pready & mapped;
  assign host_s.valid = data_wr;
  assign host_s.data  = pwdata[7:0];

  wire cfg_ok    = ctrl[`USC_CTRL_VALID];
  wire bitbang   = ctrl[`USC_CTRL_BITBANG];
  wire [7:0] dir = ctrl[`USC_CTRL_DIR_LSB +: 8];
  wire [31:0] stat_word = {25'h0, serial_present, port_s.valid,
                           usb_configured, usb_suspend, self_powered,
                           op_clk_48, alt_pid};
  wire [31:0] rd_word =
    sel_ctrl ? ctrl :
    sel_baud ? {15'h0, baud_frac, baud_n} :
    sel_tmo  ? {24'h0, tmo} :
    sel_data ? {24'h0, li_sync} :
    sel_stat ? stat_word :
    sel_desc ? {bcd_usb, product_id} : 32'h0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= `USC_RST_CTRL;
      baud_n    <= `USC_RST_BAUD_N;
      baud_frac <= 3'h0;
      tmo       <= `USC_RST_TMO;
      prdata    <= 32'h0;
    end else begin
      if (psel & ~penable & ~pwrite) prdata <= rd_word;
      if (wr_en & sel_ctrl) ctrl <= pwdata;
      if (wr_en & sel_baud) begin
        baud_n    <= pwdata[13:0];
        baud_frac <= pwdata[`USC_BAUD_FRAC_LSB +: 3];
      end
      if (wr_en & sel_tmo) tmo <= pwdata[7:0];
    end
  end

  // pad synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sk_sync <= 2'h0;
      cs_sync <= 2'h0;
      ps_sync <= 2'h0;
      ri_sync <= 2'h3;
      li_meta <= 8'h0;
      li_sync <= 8'h0;
    end else begin
      sk_sync <= {sk_sync[0], cfg_mem_clock_i};
      cs_sync <= {cs_sync[0], cfg_mem_select_i};
      ps_sync <= {ps_sync[0], power_source_strap};
      ri_sync <= {ri_sync[0], ring_indicator_n};
      li_meta <= line_i;
      li_sync <= li_meta;
    end
  end

  // straps are read after release, while the pads still float pulled up
  wire strap_now = (strap_cnt == 3'(`USC_STRAP_CYCLES));
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_st  <= usc_pkg::USC_STRAP_WAIT;
      strap_cnt <= 3'h0;
      alt_pid   <= 1'b0;
      op_clk_48 <= 1'b0;
    end else begin
      unique case (strap_st)
        usc_pkg::USC_STRAP_WAIT: begin
          strap_cnt <= strap_cnt + 3'h1;
          if (strap_now) begin
            alt_pid   <= ~sk_sync[1];
            op_clk_48 <= ~cs_sync[1];
            strap_st  <= usc_pkg::USC_STRAP_RUN;
          end
        end
        usc_pkg::USC_STRAP_RUN: strap_cnt <= strap_cnt;
      endcase
    end
  end

  wire run = (strap_st == usc_pkg::USC_STRAP_RUN);
  // the memory engine sits elsewhere; pins idle low once driven
  assign cfg_mem_clock_o   = 1'b0;
  assign cfg_mem_clock_oe  = run;
  assign cfg_mem_select_o  = 1'b0;
  assign cfg_mem_select_oe = run;
  assign cfg_mem_data_o    = 1'b0;
  assign cfg_mem_data_oe   = 1'b0;
  assign cfg_mem_words     = 7'(CFG_WORDS);

  assign product_id     = alt_pid ? PID_ALT : PID_BASE;
  assign bcd_usb        = (cfg_ok & ctrl[`USC_CTRL_USB2]) ?
                          `USC_BCD_USB20 : `USC_BCD_USB11;
  assign serial_present = cfg_ok;
  assign self_powered   = ps_sync[1];
  assign uart_pulldown  = cfg_ok & ctrl[`USC_CTRL_PULLDOWN]
                        & power_enable_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_n             <= 1'b1;
      power_enable_n      <= 1'b1;
      rs485_driver_enable <= 1'b0;
    end else begin
      sleep_n             <= ~usb_suspend;
      power_enable_n      <= ~(usb_configured & ~usb_suspend);
      rs485_driver_enable <= tx_busy | tx_break;
    end
  end

  // 48MHz reference as a fractional enable on the core clock
  wire [7:0] acc48_sum = {1'b0, acc48} + 8'(`USC_REF_MHZ);
  wire       ref_tick  = (acc48_sum >= 8'(`USC_CLK_MHZ));
  wire [7:0] next_acc48_w = ref_tick ? acc48_sum - 8'(`USC_CLK_MHZ)
                                     : acc48_sum;
  // divisor in eighths of a reference period
  wire [16:0] div8 =
    (baud_n == 14'h0) ? `USC_DIV8_VAL0 :
    (baud_n == 14'h1) ? `USC_DIV8_VAL1 :
    {baud_n, baud_frac};
  wire [17:0] bacc_sum = bacc + 18'h8;
  assign baud_x16_tick = ref_tick & (bacc_sum >= {1'b0, div8});

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc48 <= 7'h0;
      bacc  <= 18'h0;
    end else begin
      acc48 <= next_acc48_w[6:0];
      if (wr_en & sel_baud) bacc <= 18'h0; // no burst after a smaller divisor
      else if (baud_x16_tick) bacc <= bacc_sum - {1'b0, div8};
      else if (ref_tick) bacc <= bacc_sum;
    end
  end

  // parallel io: one buffered byte per oversampling tick
  assign port_s.ready = bitbang & baud_x16_tick;
  assign line_o  = bitbang ? bb_out : uart_line_o;
  assign line_oe = bitbang ? dir : uart_line_oe;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) bb_out <= 8'h0;
    else if (port_s.valid & port_s.ready) bb_out <= port_s.data;
  end

  // flush timer restarts on every received byte
  wire ms_tick   = (ms_cnt == 32'(MS_CYCLES - 1));
  wire [7:0] tmo_eff = (tmo == 8'h0) ? 8'h1 : tmo;
  wire flush_now = rx_data_pending & ms_tick
                 & (ms_elapsed + 8'h1 >= tmo_eff);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ms_cnt       <= 32'h0;
      ms_elapsed   <= 8'h0;
      rx_flush_req <= 1'b0;
    end else begin
      rx_flush_req <= flush_now;
      if (rx_activity | ~rx_data_pending | flush_now) begin
        ms_cnt     <= 32'h0;
        ms_elapsed <= 8'h0;
      end else if (ms_tick) begin
        ms_cnt     <= 32'h0;
        ms_elapsed <= ms_elapsed + 8'h1;
      end else begin
        ms_cnt <= ms_cnt + 32'h1;
      end
    end
  end

  // ring pulse must be held low the whole time; one wake per pulse
  wire wake_ok = usb_suspend & cfg_ok & ctrl[`USC_CTRL_WAKE];
  wire ri_hit  = (ri_cnt == 32'(RING_CYCLES - 1));
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ri_cnt        <= 32'h0;
      ri_done       <= 1'b0;
      remote_wakeup <= 1'b0;
    end else begin
      remote_wakeup <= 1'b0;
      if (~wake_ok | ri_sync[1]) begin
        ri_cnt  <= 32'h0;
        ri_done <= 1'b0;
      end else if (!ri_done) begin
        ri_cnt <= ri_cnt + 32'h1;
        if (ri_hit) begin
          ri_done       <= 1'b1;
          remote_wakeup <= 1'b1;
        end
      end
    end
  end

  property p_mem_clk_drive;
    run |-> cfg_mem_clock_oe && !cfg_mem_data_oe;
  endproperty
  a_mem_clk_drive: assert property (p_mem_clk_drive)
    else $error("memory clock not driven after strap sampling");

  property p_alt_pid;
    $rose(run) |-> product_id == ($past(sk_sync[1]) ? PID_BASE : PID_ALT);
  endproperty
  a_alt_pid: assert property (p_alt_pid)
    else $error("product id does not follow strap");

  property p_suspend;
    usb_suspend |=> !sleep_n && power_enable_n;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend not reflected on outputs");

  property p_power_en;
    !power_enable_n |-> $past(usb_configured) && !$past(usb_suspend);
  endproperty
  a_power_en: assert property (p_power_en)
    else $error("power enabled without configuration");

  property p_pulldown;
    uart_pulldown |-> power_enable_n && cfg_ok;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pulldown while power enabled");

  property p_flush;
    rx_flush_req |-> $past(rx_data_pending) && $past(ms_tick);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush without pending data");

  property p_div3m;
    (baud_n == 14'h0 && ref_tick) |-> baud_x16_tick;
  endproperty
  a_div3m: assert property (p_div3m)
    else $error("divisor 0 must tick every reference period");

  property p_bb_pace;
    (port_s.valid && port_s.ready) |-> baud_x16_tick && bitbang;
  endproperty
  a_bb_pace: assert property (p_bb_pace)
    else $error("parallel byte out of pace");

  property p_break_en;
    tx_break |=> rs485_driver_enable;
  endproperty
  a_break_en: assert property (p_break_en)
    else $error("driver enable dropped during break");

  property p_serial;
    !cfg_ok |-> !serial_present && bcd_usb == `USC_BCD_USB11;
  endproperty
  a_serial: assert property (p_serial)
    else $error("defaults not used for invalid memory");

  c_bb_byte: cover property (port_s.valid && port_s.ready);
  c_flush:   cover property (rx_flush_req);
  c_stall:   cover property (data_wr && !pready);
  c_wake:    cover property (remote_wakeup);
endmodule // usc_top

// >>> test/usc_far_side.sv
`timescale 1ns/1ps
module usc_far_side (
  input  wire logic       core_clk,
  input  wire logic       clk_pd,
  input  wire logic       sel_pd,
  input  wire logic       self_pwr,
  input  wire logic       mck_o,
  input  wire logic       mck_oe,
  output logic            mck_i,
  input  wire logic       msel_o,
  input  wire logic       msel_oe,
  output logic            msel_i,
  input  wire logic       mdat_o,
  input  wire logic       mdat_oe,
  output logic            mdat_i,
  input  wire logic [7:0] line_o,
  input  wire logic [7:0] line_oe,
  output logic      [7:0] line_i,
  output logic            power_source_strap
);
  logic [7:0] noise = 8'h00;
  // a board pull-down outweighs the weak pull-up of a released pin
  assign mck_i = mck_oe ? mck_o : !clk_pd;
  assign msel_i = msel_oe ? msel_o : !sel_pd;
  assign mdat_i = mdat_oe ? mdat_o : 1'b1;
  assign power_source_strap = self_pwr;
  // undriven port lines float: a moving pattern hides any stale value
  always @(posedge core_clk) noise <= noise + 8'h5b;
  assign line_i = (line_oe & line_o) | (~line_oe & noise);
endmodule // usc_far_side

// >>> test/uart_side_control_logic_tb.sv
`timescale 1ns/1ps
`include "usc_cfg.svh"
module uart_side_control_logic_tb;
  localparam int          MS   = 20;
  localparam int          RING = 30;
  localparam logic [15:0] PB   = 16'h2a51; // arbitrary value
  localparam logic [15:0] PA   = 16'h2a52; // arbitrary value
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, uart_line_o, uart_line_oe, line_o, line_oe, line_i, b;
  logic [31:0] pwdata, prdata, rd;
  logic        mck_o, mck_oe, mck_i, msel_o, msel_oe, msel_i;
  logic        mdat_o, mdat_oe, mdat_i, clk_pd, sel_pd, self_pwr;
  logic        usb_suspend, usb_configured, sleep_n, power_enable_n;
  logic        power_source_strap, self_powered, op_clk_48, uart_pulldown;
  logic        rx_data_pending, rx_activity, rx_flush_req, baud_x16_tick;
  logic        tx_busy, tx_break, rs485_driver_enable, ring_indicator_n;
  logic        remote_wakeup, serial_present;
  logic [15:0] product_id, bcd_usb;
  logic [6:0]  cfg_mem_words;
  logic [7:0]  seen[$], sent[$];
  int          error_cnt, checks_done, seed, ticks, wakes, waits, n, f, t;

  usc_top #(.MS_CYCLES(MS), .RING_CYCLES(RING), .PID_BASE(PB),
            .PID_ALT(PA)) u_dut (
    .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr,
    .cfg_mem_clock_o(mck_o), .cfg_mem_clock_oe(mck_oe),
    .cfg_mem_clock_i(mck_i), .cfg_mem_select_o(msel_o),
    .cfg_mem_select_oe(msel_oe), .cfg_mem_select_i(msel_i),
    .cfg_mem_data_o(mdat_o), .cfg_mem_data_oe(mdat_oe),
    .cfg_mem_data_i(mdat_i), .usb_suspend, .usb_configured, .sleep_n,
    .power_enable_n, .power_source_strap, .self_powered, .op_clk_48,
    .uart_pulldown, .rx_data_pending, .rx_activity, .rx_flush_req,
    .baud_x16_tick, .tx_busy, .tx_break, .rs485_driver_enable,
    .uart_line_o, .uart_line_oe, .line_o, .line_oe, .line_i,
    .ring_indicator_n, .remote_wakeup, .product_id, .bcd_usb,
    .serial_present, .cfg_mem_words);

  usc_far_side u_far (
    .core_clk, .clk_pd, .sel_pd, .self_pwr, .mck_o, .mck_oe, .mck_i,
    .msel_o, .msel_oe, .msel_i, .mdat_o, .mdat_oe, .mdat_i, .line_o,
    .line_oe, .line_i, .power_source_strap);

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    ticks += int'(baud_x16_tick);
    wakes += int'(remote_wakeup);
    if (line_oe === 8'hff && line_o !== 8'h00 &&
        (seen.size() == 0 || seen[$] !== line_o))
      seen.push_back(line_o);
  end

  function automatic int exp_ticks(int nn, int ff);
    return 7680 / (nn == 0 ? 8 : nn == 1 ? 12 : nn * 8 + ff);
  endfunction

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task sn(input int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    waits = 0;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rst(input logic c, input logic s);
    @(posedge core_clk);
    clk_pd <= c; sel_pd <= s; resetn <= 0;
    sn(1);
    chk("oe_in_reset", {mck_oe, msel_oe, mdat_oe}, 0);
    @(posedge core_clk);
    resetn <= 1;
    sn(10);
    chk("mem_oe", {mck_oe, msel_oe, mdat_oe}, 3'b110);
    chk("clk48", op_clk_48, s);
    chk("pid", product_id, c ? PA : PB);
    $display("test reset strap %b%b done", c, s);
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // about 20k cycles of tests; three times that means a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    seed = 32'he7c159b0;
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    {usb_suspend, usb_configured, rx_data_pending, rx_activity} = '0;
    {tx_busy, tx_break, uart_line_o, uart_line_oe} = '0;
    {clk_pd, sel_pd} = '0;
    self_pwr = 1'($random(seed));
    ring_indicator_n = 1;
    rst(0, 0);
    rst(1, 1);
    chk("self_pwr", self_powered, self_pwr);
    xfer(8'h10, 0, 0);
    chk("stat", rd, {29'h0, self_pwr, 2'h3});
    xfer(8'h20, 0, 0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    xfer(8'h00, 1, 32'h14);
    xfer(8'h14, 0, 0);
    chk("desc", rd, {`USC_BCD_USB20, PA});
    chk("serial", serial_present, 1);
    chk("words", cfg_mem_words, 64);
    xfer(8'h00, 1, 0);
    sn(0);
    chk("bcd11", bcd_usb, `USC_BCD_USB11);
    chk("no_serial", serial_present, 0);
    $display("test descriptor done");
    xfer(8'h00, 1, 32'h12);
    sn(1);
    chk("pd_on", uart_pulldown, 1);
    @(posedge core_clk);
    usb_configured <= 1;
    sn(2);
    chk("power_enable_n", power_enable_n, 0);
    chk("pd_off", uart_pulldown, 0);
    @(posedge core_clk);
    usb_suspend <= 1;
    sn(2);
    chk("sleep", sleep_n, 0);
    chk("power_enable_n_susp", power_enable_n, 1);
    xfer(8'h00, 1, 32'h18);
    sn(0);
    wakes = 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      ring_indicator_n <= 0;
      repeat (k ? RING + 10 : 10) @(posedge core_clk);
      ring_indicator_n <= 1;
      sn(4);
      chk("wake", wakes, k);
    end
    @(posedge core_clk);
    usb_suspend <= 0;
    sn(2);
    chk("awake", sleep_n, 1);
    $display("test power and wake done");
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      tx_break <= !k;
      sn(1);
      chk("rs485_driver_enable", rs485_driver_enable, !k);
    end
    // timeout boundaries 1 and 255 plus one random step count
    for (int k = 0; k < 3; k++) begin
      t = k == 0 ? 1 : k == 1 ? 255 : 2 + ($random(seed) & 8'h7f);
      xfer(8'h08, 1, t);
      @(posedge core_clk);
      rx_data_pending <= 1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (rx_flush_req !== 1'b1 && n < 6000);
      chk("flush", n >= t * MS - 2 && n <= t * MS + 4, 1);
      rx_data_pending <= 0;
      rx_activity <= 1;
      @(posedge core_clk);
      rx_activity <= 0;
    end
    $display("test flush done");
    // 0 and 1 carry a random fraction that must be ignored
    for (int k = 0; k < 6; k++) begin
      n = k < 2 ? k : 2 + ($random(seed) & 63);
      f = $random(seed) & 7;
      xfer(8'h04, 1, {15'h0, 3'(f), 14'(n)});
      sn(0);
      ticks = 0;
      repeat (2000) @(posedge core_clk);
      t = ticks - exp_ticks(n, k < 2 ? 0 : f);
      chk("baud", t >= -3 && t <= 3, 1);
    end
    $display("test baud done");
    xfer(8'h04, 1, 100);
    xfer(8'h00, 1, 32'hff11);
    seen.delete();
    for (int i = 1; i <= 6; i++) begin
      b = {3'(i), 5'($random(seed))};
      sent.push_back(b);
      xfer(8'h0c, 1, {24'h0, b});
      if (i == 4) chk("full_stall", waits > 5, 1);
    end
    n = 0;
    while (seen.size() < 6 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    for (int i = 0; i < 6; i++) chk("bb_byte", seen[i], sent[i]);
    chk("bb_oe", line_oe, 8'hff);
    xfer(8'h0c, 0, 0);
    chk("bb_in", rd[7:0], sent[5]);
    @(posedge core_clk);
    uart_line_o <= 8'($random(seed));
    uart_line_oe <= 8'($random(seed));
    xfer(8'h00, 1, 32'h10);
    sn(0);
    chk("uart_back", {line_oe, line_o},
        {uart_line_oe, uart_line_o});
    $display("test parallel io done");
    wrap_up();
  end
endmodule // uart_side_control_logic_tb
